// ### hw/dss_pkg.sv
// package of constants for the deflection safety supervisor
`default_nettype none
package dss_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses, word aligned)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_ST = 4'h8;
  localparam logic [3:0] OFF_IRQ_MK = 4'hc;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_DRIVE_EN  = 0;
  localparam int CTRL_VDRV_EN   = 1;
  localparam int CTRL_BLANK_HLD = 2;
  localparam int CTRL_SENSE_INPUT_A_CLR  = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int ST_SENSE_INPUT_A_ALARM = 0;
  localparam int ST_HDRV_ON    = 1;
  localparam int ST_CDRV_ON    = 2;
  localparam int ST_LOCK       = 3;
  localparam int ST_VBLANK     = 4;
  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  localparam int IRQ_SENSE_INPUT_A   = 0;
  localparam int IRQ_UNLOCK = 1;
  localparam int IRQ_W      = 2;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SENSE_INPUT_A_LINES    = 2;
  localparam int SEQ_GAP_NS    = 1000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEQ_GAP_CYC   = (SEQ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // composite output levels, two bits
  localparam logic [1:0] LVL_LOCK_ACT   = 2'h0;
  localparam logic [1:0] LVL_LOCK_BLANK = 2'h1;
  localparam logic [1:0] LVL_UNLK_ACT   = 2'h2;
  localparam logic [1:0] LVL_UNLK_BLANK = 2'h3;
  typedef enum logic [1:0] {SEQ_OFF, SEQ_H_ON, SEQ_BOTH_ON, SEQ_C_OFF} dss_seq_t;
endpackage
`default_nettype wire

// ### hw/dss_sync.sv
// two-flop synchroniser for external levels
`default_nettype none
module dss_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end
  assign q = s2_q;
endmodule
`default_nettype wire

// ### hw/dss_top.sv
// deflection safety supervisor: x-ray latch, drive sequencing, composite out
//
// Behaviour
// - X-ray protection starts when the sense comparator reports above-threshold.
// - Once detected, both drives switch off after two horizontal line periods.
// - Engaged protection sets the readable x-ray alarm flag to one.
// - Protection stays latched until supply dropout or the x-ray clear bit is written.
// - Drives use the same phase-in and phase-out order whatever the cause.
// - Horizontal drive turns on before and off after the converter drive.
// - The composite output encodes lock and blanking as one of four levels.
// - Early blanking starts at the first leading edge of vertical sync or discharge.
// - Early blanking ends at the trailing edge of the discharge pulse.
// - With blank hold select at one, the default, blanking shows permanently.
// - Low supply, x-ray protection or disabled vertical drive forces blanking.
`default_nettype none
module dss_top #(
  parameter int GAP_CYC = dss_pkg::SEQ_GAP_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sense_input_a,
  input  wire logic        hline_clk,
  input  wire logic        vsync_in,
  input  wire logic        vdischarge_in,
  input  wire logic        loop_locked,
  input  wire logic        supply_low,
  output logic             horizontal_drive_output,
  output logic             converter_drive_output,
  output logic [1:0]       lock_blank_composite_out,
  output logic             irq
);
  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (GAP_CYC < 1 || GAP_CYC > 65535) begin : g_gap_chk
    $error("GAP_CYC out of range");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [5:0] raw_w;
  logic [5:0] syn_w;
  assign raw_w = {supply_low, loop_locked, vdischarge_in, vsync_in, hline_clk, sense_input_a};
  dss_sync #(.W(6)) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (raw_w),
    .q     (syn_w)
  );
  logic sense_input_a_s;
  logic hclk_s;
  logic vsync_s;
  logic vdis_s;
  logic lock_s;
  logic slow_s;
  assign sense_input_a_s  = syn_w[0];
  assign hclk_s  = syn_w[1];
  assign vsync_s = syn_w[2];
  assign vdis_s  = syn_w[3];
  assign lock_s  = syn_w[4];
  assign slow_s  = syn_w[5];

  // ----------------------------------------------------------------
  // edge history
  // ----------------------------------------------------------------
  // level now high that was low one clock ago
  function automatic logic rise(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction
  logic hclk_q;
  logic vsync_q;
  logic vdis_q;
  logic lock_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hclk_q  <= 1'b0;
      vsync_q <= 1'b0;
      vdis_q  <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      hclk_q  <= hclk_s;
      vsync_q <= vsync_s;
      vdis_q  <= vdis_s;
      lock_q  <= lock_s;
    end
  end
  logic line_tick;
  assign line_tick = rise(hclk_s, hclk_q);

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [3:0]               ctrl_q;
  logic [3:0]               ctrl_d;
  logic [dss_pkg::IRQ_W-1:0] ist_q;
  logic [dss_pkg::IRQ_W-1:0] ist_d;
  logic [dss_pkg::IRQ_W-1:0] imk_q;
  logic [dss_pkg::IRQ_W-1:0] imk_d;
  logic [31:0]              rdata_q;
  logic [31:0]              rdata_d;
  logic                     ack_q;
  logic                     ack_d;
  logic                     sense_input_a_latch_q;
  logic                     sense_input_a_latch_d;
  logic [1:0]               line_cnt_q;
  logic [1:0]               line_cnt_d;
  dss_pkg::dss_seq_t        seq_q;
  dss_pkg::dss_seq_t        seq_d;
  logic                     vblank_q;
  logic                     vblank_d;
  logic                     sense_input_a_clr;
  logic                     wr_ctrl;

  // one wait cycle per access: answered on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_ctrl  = avs_write & ack_q & (avs_address == dss_pkg::OFF_CTRL) & avs_byteenable[0];
  assign sense_input_a_clr = wr_ctrl & avs_writedata[dss_pkg::CTRL_SENSE_INPUT_A_CLR];

  logic [4:0] status_w;
  always_comb begin
    status_w = '0;
    status_w[dss_pkg::ST_SENSE_INPUT_A_ALARM] = sense_input_a_latch_q;
    status_w[dss_pkg::ST_HDRV_ON]    = horizontal_drive_output;
    status_w[dss_pkg::ST_CDRV_ON]    = converter_drive_output;
    status_w[dss_pkg::ST_LOCK]       = lock_q;
    status_w[dss_pkg::ST_VBLANK]     = vblank_q;
  end

  logic [dss_pkg::IRQ_W-1:0] ev_w;
  assign ev_w[dss_pkg::IRQ_SENSE_INPUT_A]   = rise(sense_input_a_latch_d, sense_input_a_latch_q);
  assign ev_w[dss_pkg::IRQ_UNLOCK] = rise(~lock_s, ~lock_q);

  always_comb begin
    ack_d   = (avs_read | avs_write) & ~ack_q;
    rdata_d = rdata_q;
    ctrl_d  = ctrl_q;
    imk_d   = imk_q;
    ist_d   = ist_q;
    if (avs_read & ~ack_q) begin
      case (avs_address)
        dss_pkg::OFF_CTRL:   rdata_d = {28'h0, 1'b0, ctrl_q[2:0]};
        dss_pkg::OFF_STATUS: rdata_d = {27'h0, status_w};
        dss_pkg::OFF_IRQ_ST: rdata_d = {30'h0, ist_q};
        dss_pkg::OFF_IRQ_MK: rdata_d = {30'h0, imk_q};
        default:             rdata_d = 32'h0;
      endcase
    end
    if (wr_ctrl) begin
      ctrl_d = {1'b0, avs_writedata[2:0]};
    end
    if (avs_write & ack_q & avs_byteenable[0]) begin
      if (avs_address == dss_pkg::OFF_IRQ_MK) begin
        imk_d = avs_writedata[dss_pkg::IRQ_W-1:0];
      end
      if (avs_address == dss_pkg::OFF_IRQ_ST) begin
        ist_d = ist_q & ~avs_writedata[dss_pkg::IRQ_W-1:0];
      end
    end
    ist_d = ist_d | ev_w;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= dss_pkg::CTRL_RESET;
      imk_q   <= '0;
      ist_q   <= '0;
      rdata_q <= 32'h0;
      ack_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      imk_q   <= imk_d;
      ist_q   <= ist_d;
      rdata_q <= rdata_d;
      ack_q   <= ack_d;
    end
  end
  assign avs_readdata = rdata_q;
  assign irq = |(ist_q & imk_q);

  // ----------------------------------------------------------------
  // x-ray protection
  // ----------------------------------------------------------------
  always_comb begin
    line_cnt_d   = line_cnt_q;
    sense_input_a_latch_d = sense_input_a_latch_q;
    if (!sense_input_a_s) begin
      line_cnt_d = 2'h0;
    end else if (line_tick && line_cnt_q < 2'(dss_pkg::SENSE_INPUT_A_LINES)) begin
      line_cnt_d = line_cnt_q + 2'h1;
    end
    if (sense_input_a_clr) begin
      sense_input_a_latch_d = 1'b0;
      line_cnt_d   = 2'h0;
    end
    if (sense_input_a_s && line_cnt_q == 2'(dss_pkg::SENSE_INPUT_A_LINES)) begin
      sense_input_a_latch_d = 1'b1;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      line_cnt_q   <= 2'h0;
      sense_input_a_latch_q <= 1'b0;
    end else begin
      line_cnt_q   <= line_cnt_d;
      sense_input_a_latch_q <= sense_input_a_latch_d;
    end
  end

  // ----------------------------------------------------------------
  // drive sequencer
  // ----------------------------------------------------------------
  logic        want_on;
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic        hdrv_q;
  logic        hdrv_d;
  logic        cdrv_q;
  logic        cdrv_d;
  assign want_on = ctrl_q[dss_pkg::CTRL_DRIVE_EN] & ~sense_input_a_latch_q & ~slow_s;
  always_comb begin
    seq_d = seq_q;
    gap_d = (gap_q != 16'h0) ? gap_q - 16'h1 : 16'h0;
    case (seq_q)
      dss_pkg::SEQ_OFF: begin
        if (want_on) begin
          seq_d = dss_pkg::SEQ_H_ON;
          gap_d = 16'(GAP_CYC);
        end
      end
      dss_pkg::SEQ_H_ON: begin
        if (!want_on) begin
          seq_d = dss_pkg::SEQ_OFF;
        end else if (gap_q == 16'h0) begin
          seq_d = dss_pkg::SEQ_BOTH_ON;
        end
      end
      dss_pkg::SEQ_BOTH_ON: begin
        if (!want_on) begin
          seq_d = dss_pkg::SEQ_C_OFF;
          gap_d = 16'(GAP_CYC);
        end
      end
      dss_pkg::SEQ_C_OFF: begin
        if (gap_q == 16'h0) begin
          seq_d = dss_pkg::SEQ_OFF;
        end
      end
      default: seq_d = dss_pkg::SEQ_OFF;
    endcase
    hdrv_d = (seq_d != dss_pkg::SEQ_OFF);
    cdrv_d = (seq_d == dss_pkg::SEQ_BOTH_ON);
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_q  <= dss_pkg::SEQ_OFF;
      gap_q  <= 16'h0;
      hdrv_q <= 1'b0;
      cdrv_q <= 1'b0;
    end else begin
      seq_q  <= seq_d;
      gap_q  <= gap_d;
      hdrv_q <= hdrv_d;
      cdrv_q <= cdrv_d;
    end
  end
  assign horizontal_drive_output = hdrv_q;
  assign converter_drive_output  = cdrv_q;

  // ----------------------------------------------------------------
  // early vertical blanking and composite output
  // ----------------------------------------------------------------
  logic [1:0] comp_q;
  logic [1:0] comp_d;
  logic       blank_all;
  always_comb begin
    vblank_d = vblank_q;
    if (rise(vsync_s, vsync_q) | rise(vdis_s, vdis_q)) begin
      vblank_d = 1'b1;
    end else if (rise(~vdis_s, ~vdis_q)) begin
      vblank_d = 1'b0;
    end
    blank_all = vblank_q | ctrl_q[dss_pkg::CTRL_BLANK_HLD]
              | slow_s | sense_input_a_latch_q | ~ctrl_q[dss_pkg::CTRL_VDRV_EN];
    case ({lock_q, blank_all})
      2'b11:   comp_d = dss_pkg::LVL_LOCK_BLANK;
      2'b10:   comp_d = dss_pkg::LVL_LOCK_ACT;
      2'b01:   comp_d = dss_pkg::LVL_UNLK_BLANK;
      default: comp_d = dss_pkg::LVL_UNLK_ACT;
    endcase
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      vblank_q <= 1'b0;
      comp_q   <= dss_pkg::LVL_UNLK_BLANK;
    end else begin
      vblank_q <= vblank_d;
      comp_q   <= comp_d;
    end
  end
  assign lock_blank_composite_out = comp_q;
endmodule
`default_nettype wire

// ### tb/dss_monitor.sv
// assertion checker for the deflection safety supervisor ports
`default_nettype none
module dss_monitor #(
  parameter int GAP_CYC = dss_pkg::SEQ_GAP_CYC
) (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       sense_input_a,
  input wire logic       loop_locked,
  input wire logic       supply_low,
  input wire logic       horizontal_drive_output,
  input wire logic       converter_drive_output,
  input wire logic [1:0] lock_blank_composite_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // cycles of sense high, saturating
  // ----------------------------------------
  localparam int XR_CHK = 30 + 2 * GAP_CYC;
  localparam int SOFF_MAX = GAP_CYC + 4;
  logic [7:0] xr_q;
  logic [7:0] xr_d;
  always_comb xr_d = !sense_input_a ? 8'h00 : xr_q + {7'h0, xr_q != 8'hff};
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) xr_q <= 8'h00;
    else xr_q <= xr_d;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_req;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_sense_input_a;
    xr_q == 8'(XR_CHK);
  endsequence
  property p_wait;
    s_req |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("waitrequest without request");
  property p_order;
    converter_drive_output |-> horizontal_drive_output;
  endproperty
  a_order: assert property (p_order) else $error("converter on without horizontal");
  property p_xoff;
    s_sense_input_a |-> !horizontal_drive_output && !converter_drive_output;
  endproperty
  a_xoff: assert property (p_xoff) else $error("drives on during x-ray");
  property p_xblank;
    s_sense_input_a |-> lock_blank_composite_out[0];
  endproperty
  a_xblank: assert property (p_xblank) else $error("no blanking during x-ray");
  property p_sblank;
    supply_low[*6] |-> lock_blank_composite_out[0];
  endproperty
  a_sblank: assert property (p_sblank) else $error("no blanking at low supply");
  property p_soff;
    supply_low[*8] |-> !converter_drive_output ##[0:SOFF_MAX] !horizontal_drive_output;
  endproperty
  a_soff: assert property (p_soff) else $error("drives not off at low supply");
  property p_lock;
    loop_locked[*6] |-> !lock_blank_composite_out[1];
  endproperty
  a_lock: assert property (p_lock) else $error("lock level wrong");
  property p_unlk;
    (!loop_locked)[*6] |-> lock_blank_composite_out[1];
  endproperty
  a_unlk: assert property (p_unlk) else $error("unlock level wrong");
endmodule
bind dss_top dss_monitor #(.GAP_CYC(GAP_CYC)) dss_monitor_inst (
  .clock(clock), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sense_input_a(sense_input_a),
  .loop_locked(loop_locked), .supply_low(supply_low),
  .horizontal_drive_output(horizontal_drive_output),
  .converter_drive_output(converter_drive_output),
  .lock_blank_composite_out(lock_blank_composite_out));
`default_nettype wire

// ### tb/dss_scan_model.sv
// scan source model: free line clock and one vertical frame on request
`default_nettype none
module dss_scan_model (
  input  wire logic clock,
  input  wire logic frame,
  output logic      hline_clk,
  output logic      vsync_in = 1'b0,
  output logic      vdischarge_in = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  int n = 99;
  // line clock phase unrelated to the system clock
  initial begin
    hline_clk = 1'b0;
    #3;
    forever #80 hline_clk = ~hline_clk;
  end
  // sync first, discharge overlaps and outlasts it
  always @(posedge clock) begin
    if (frame) n <= 0;
    else if (n < 99) n <= n + 1;
    vsync_in <= (n < 6);
    vdischarge_in <= (n >= 4 && n < 20);
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the deflection safety supervisor
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sense_input_a = 1'b0;
  logic        loop_locked = 1'b1;
  logic        supply_low = 1'b0;
  logic        frame = 1'b0;
  logic        hline_clk, vsync_in, vdischarge_in, hdrv, cdrv, irq;
  logic [1:0]  comp;
  logic [31:0] seed = 32'h41, r, x;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;
  dss_top #(.GAP_CYC(2)) dss_top_inst (
    .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sense_input_a(sense_input_a), .hline_clk(hline_clk), .vsync_in(vsync_in),
    .vdischarge_in(vdischarge_in), .loop_locked(loop_locked), .supply_low(supply_low),
    .horizontal_drive_output(hdrv), .converter_drive_output(cdrv),
    .lock_blank_composite_out(comp), .irq(irq));
  dss_scan_model dss_scan_model_inst (.clock(clock), .frame(frame),
    .hline_clk(hline_clk), .vsync_in(vsync_in), .vdischarge_in(vdischarge_in));
  initial forever #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // composite level: upper bit unlocked, lower bit blanking
  function automatic logic [31:0] lvl(input logic lk, input logic bl);
    return {30'h0, !lk, bl};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    x = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(x, e);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rdc(dss_pkg::OFF_CTRL, 32'h4);
    xfer(1'b1, 4'h1, 32'hff);
    rdc(4'h1, 32'h0);
    rdc(dss_pkg::OFF_IRQ_MK, 32'h0);
    xfer(1'b1, dss_pkg::OFF_CTRL, 32'h3);
    repeat (20) @(posedge clock);
    rdc(dss_pkg::OFF_STATUS, 32'he);
    $display("reset and start test done");
    repeat (8) begin
      r = xs();
      xfer(1'b1, dss_pkg::OFF_CTRL, {29'h0, r[2:1], 1'b1});
      loop_locked <= r[0];
      repeat (8) @(posedge clock);
      @(negedge clock);
      check(32'(comp), lvl(r[0], r[2] | !r[1]));
    end
    xfer(1'b1, dss_pkg::OFF_CTRL, 32'h3);
    loop_locked <= 1'b1;
    xfer(1'b1, dss_pkg::OFF_IRQ_ST, 32'h3);
    repeat (8) @(posedge clock);
    frame <= 1'b1;
    @(posedge clock);
    frame <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    check(32'(comp), lvl(1'b1, 1'b1));
    repeat (6) @(posedge clock);
    @(negedge clock);
    check(32'(comp), lvl(1'b1, 1'b1));
    repeat (17) @(posedge clock);
    @(negedge clock);
    check(32'(comp), lvl(1'b1, 1'b0));
    $display("composite test done");
    @(posedge clock);
    sense_input_a <= 1'b1;
    repeat (3) @(posedge clock);
    sense_input_a <= 1'b0;
    repeat (40) @(posedge clock);
    rdc(dss_pkg::OFF_STATUS, 32'he);
    xfer(1'b1, dss_pkg::OFF_IRQ_MK, 32'h1);
    sense_input_a <= 1'b1;
    repeat (50) @(posedge clock);
    @(negedge clock);
    check({30'h0, hdrv, cdrv}, 32'h0);
    check(32'(irq), 32'h1);
    @(posedge clock);
    sense_input_a <= 1'b0;
    repeat (30) @(posedge clock);
    rdc(dss_pkg::OFF_STATUS, 32'h9);
    rdc(dss_pkg::OFF_IRQ_ST, 32'h1);
    xfer(1'b1, dss_pkg::OFF_IRQ_MK, 32'h0);
    @(negedge clock);
    check(32'(irq), 32'h0);
    xfer(1'b1, dss_pkg::OFF_IRQ_MK, 32'h1);
    xfer(1'b1, dss_pkg::OFF_IRQ_ST, 32'h1);
    @(negedge clock);
    check(32'(irq), 32'h0);
    xfer(1'b1, dss_pkg::OFF_CTRL, 32'hb);
    repeat (20) @(posedge clock);
    rdc(dss_pkg::OFF_STATUS, 32'he);
    rdc(dss_pkg::OFF_CTRL, 32'h3);
    $display("x-ray test done");
    supply_low <= 1'b1;
    repeat (20) @(posedge clock);
    @(negedge clock);
    check(32'(comp), lvl(1'b1, 1'b1));
    rdc(dss_pkg::OFF_STATUS, 32'h8);
    supply_low <= 1'b0;
    repeat (20) @(posedge clock);
    $display("supply test done");
    sense_input_a <= 1'b1;
    repeat (40) @(posedge clock);
    sense_input_a <= 1'b0;
    rst_n <= 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    @(negedge clock);
    check(32'(irq), 32'h0);
    rdc(dss_pkg::OFF_STATUS, 32'h8);
    $display("supply dropout test done");
    test_done();
  end
endmodule
`default_nettype wire
